/* dtg_regs.vh */
// Register map, field positions, reset values and tone timing constants
// for the dual-tone dial generator. Definitions only; included by bare name.
`ifndef DTG_REGS_VH
`define DTG_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define DTG_ADDR_W 8
`define DTG_DATA_W 8
`define DTG_OFS_TONE_CONTROL 8'h20
`define DTG_OFS_DIAL_SELECT 8'h21

// ****************************************
// Field positions
// ****************************************
`define DTG_BIT_TONE_OUTPUT_GATE 0
`define DTG_BIT_LOW_GROUP_DISABLE 1
`define DTG_BIT_HIGH_GROUP_DISABLE 2
`define DTG_BIT_CRYSTAL_SELECT 3
`define DTG_CTRL_FIELD_W 4
`define DTG_DIAL_CODE_MSB 3
`define DTG_DIAL_CODE_W 4

// ****************************************
// Reset and read values
// ****************************************
`define DTG_CTRL_RESET 4'h0
`define DTG_DIAL_RESET 4'h0
`define DTG_READ_IDLE 8'h00
`define DTG_UNUSED_HI 4'h0

// ****************************************
// Clock divider ratios per crystal setting
// ****************************************
`define DTG_DIV_4M 8'h01
`define DTG_DIV_8M 8'h02
`define DTG_DIV_W 8

// ****************************************
// Staircase step lengths in divided ticks, 16 steps per period
// ****************************************
`define DTG_PERIOD_W 10
`define DTG_STEP_W 4
`define DTG_LOW_TONE_ONE 10'h166
`define DTG_LOW_TONE_TWO 10'h145
`define DTG_LOW_TONE_THREE 10'h125
`define DTG_LOW_TONE_FOUR 10'h10A
`define DTG_HIGH_TONE_ONE 10'h0CF
`define DTG_HIGH_TONE_TWO 10'h0BB
`define DTG_HIGH_TONE_THREE 10'h0AA
`define DTG_HIGH_TONE_FOUR 10'h099

// ****************************************
// Output levels
// ****************************************
`define DTG_SAMPLE_W 8
`define DTG_SUM_W 10
`define DTG_IDLE_LEVEL 8'h80
`define DTG_SAMPLE_ZERO 8'h00

`endif

/* dtg_stair.v */
// One staircase tone generator: 16-step sine approximation, step length set by period_in.
// Assumes tick_in is a one-cycle pulse from the divider in the same clock domain.
`timescale 1ns/1ps
`include "dtg_regs.vh"

module dtg_stair #(
	parameter PERIOD_W = `DTG_PERIOD_W
) (
	input wire clk_in,
	input wire resetn_in,
	input wire run_in,
	input wire restart_in,
	input wire tick_in,
	input wire [PERIOD_W-1:0] period_in,
	output reg [`DTG_SAMPLE_W-1:0] sample_out
);

	// ****************************************
	// Staircase table
	// ****************************************
	// Signed levels, amplitude kept small so two groups plus midpoint never wrap
	function [`DTG_SAMPLE_W-1:0] stair_level;
		input [`DTG_STEP_W-1:0] step;
		begin
			case (step)
				4'h0: stair_level = 8'h00;
				4'h1: stair_level = 8'h15;
				4'h2: stair_level = 8'h28;
				4'h3: stair_level = 8'h34;
				4'h4: stair_level = 8'h38;
				4'h5: stair_level = 8'h34;
				4'h6: stair_level = 8'h28;
				4'h7: stair_level = 8'h15;
				4'h8: stair_level = 8'h00;
				4'h9: stair_level = 8'hEB;
				4'hA: stair_level = 8'hD8;
				4'hB: stair_level = 8'hCC;
				4'hC: stair_level = 8'hC8;
				4'hD: stair_level = 8'hCC;
				4'hE: stair_level = 8'hD8;
				default: stair_level = 8'hEB;
			endcase
		end
	endfunction

	// ****************************************
	// Step timing
	// ****************************************
	reg [PERIOD_W-1:0] tick_count;
	reg [`DTG_STEP_W-1:0] step;
	wire step_end = (tick_count == period_in - {{(PERIOD_W-1){1'b0}}, 1'b1});

	always @(posedge clk_in) begin
		if (!resetn_in || !run_in || restart_in) begin
			tick_count <= {PERIOD_W{1'b0}};
			step <= {`DTG_STEP_W{1'b0}};
			sample_out <= `DTG_SAMPLE_ZERO;
		end else begin
			sample_out <= stair_level(step);
			if (tick_in) begin
				if (step_end) begin
					tick_count <= {PERIOD_W{1'b0}};
					step <= step + 4'h1;
				end else begin
					tick_count <= tick_count + {{(PERIOD_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule

/* dtg_top.v */
// Dual-tone dial generator: two byte registers, divider, row/column staircases, adder and output gate.
// Assumes a same-clock register master with one-cycle strobes; read data is valid only the cycle after.
//
// Summary of operation
// - Crystal select 0 picks the divide ratio for a 4 MHz oscillator, 1 the one for 8 MHz.
// - High-group disable at 0 lets the column tone run, at 1 it silences it.
// - Low-group disable at 0 lets the row tone run, at 1 it silences it.
// - Output gate at control bit 0 passes the composite tone to the pin when 1 and blocks it when 0.
// - Control bits 7 to 4 are unused: writes to them change nothing and reads give no meaning.
// - Writing 00000111 to the dial register selects symbol seven, third row with first column.
// - While the gate is open the pin carries, without pause, the pair chosen by the dial register.
// - Rows one to four run near 693.85, 764.31, 847.78 and 933.83 Hz at the 7.9488 MHz reference.
// - Columns one to three run near 1200.00, 1328.34 and 1461.18 Hz at that reference.
// - Digits 1 to 9 form a three by three grid, row by threes, columns one to three in order.
// - Symbols B, C and D pair column four near 1623.53 Hz with rows two, three and four.
// - Zero is row four column two, star row four column one, hash row four column three, A row one column four.
// - Row and column staircase samples are added to form the composite tone.
// - Both generators run from a divided main clock whose ratio follows crystal select.
`timescale 1ns/1ps
`include "dtg_regs.vh"

module dtg_top #(
	parameter [`DTG_DIV_W-1:0] DIV_4M = `DTG_DIV_4M,
	parameter [`DTG_DIV_W-1:0] DIV_8M = `DTG_DIV_8M
) (
	input wire clk_in,
	input wire resetn_in,
	input wire [`DTG_ADDR_W-1:0] addr_in,
	input wire [`DTG_DATA_W-1:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [`DTG_DATA_W-1:0] rdata_out,
	output reg [`DTG_SAMPLE_W-1:0] tone_out,
	output reg tone_active_out
);

	// ****************************************
	// Symbol decoding
	// ****************************************
	// Returns {row index, column index}, both zero based
	function [3:0] dial_pair;
		input [`DTG_DIAL_CODE_W-1:0] code;
		begin
			case (code)
				4'h1: dial_pair = {2'h0, 2'h0};
				4'h2: dial_pair = {2'h0, 2'h1};
				4'h3: dial_pair = {2'h0, 2'h2};
				4'h4: dial_pair = {2'h1, 2'h0};
				4'h5: dial_pair = {2'h1, 2'h1};
				4'h6: dial_pair = {2'h1, 2'h2};
				4'h7: dial_pair = {2'h2, 2'h0};
				4'h8: dial_pair = {2'h2, 2'h1};
				4'h9: dial_pair = {2'h2, 2'h2};
				4'h0: dial_pair = {2'h3, 2'h1};
				4'hA: dial_pair = {2'h3, 2'h0};
				4'hB: dial_pair = {2'h3, 2'h2};
				4'hC: dial_pair = {2'h0, 2'h3};
				4'hD: dial_pair = {2'h1, 2'h3};
				4'hE: dial_pair = {2'h2, 2'h3};
				default: dial_pair = {2'h3, 2'h3};
			endcase
		end
	endfunction

	// ****************************************
	// Step length lookup
	// ****************************************
	function [`DTG_PERIOD_W-1:0] low_period;
		input [1:0] idx;
		begin
			case (idx)
				2'h0: low_period = `DTG_LOW_TONE_ONE;
				2'h1: low_period = `DTG_LOW_TONE_TWO;
				2'h2: low_period = `DTG_LOW_TONE_THREE;
				default: low_period = `DTG_LOW_TONE_FOUR;
			endcase
		end
	endfunction

	function [`DTG_PERIOD_W-1:0] high_period;
		input [1:0] idx;
		begin
			case (idx)
				2'h0: high_period = `DTG_HIGH_TONE_ONE;
				2'h1: high_period = `DTG_HIGH_TONE_TWO;
				2'h2: high_period = `DTG_HIGH_TONE_THREE;
				default: high_period = `DTG_HIGH_TONE_FOUR;
			endcase
		end
	endfunction

	// Sign extension for adding staircase samples
	function [`DTG_SUM_W-1:0] widen_signed;
		input [`DTG_SAMPLE_W-1:0] value;
		begin
			widen_signed = {{(`DTG_SUM_W-`DTG_SAMPLE_W){value[`DTG_SAMPLE_W-1]}}, value};
		end
	endfunction

	// ****************************************
	// Register storage
	// ****************************************
	reg [`DTG_CTRL_FIELD_W-1:0] tone_control;
	reg [`DTG_DIAL_CODE_W-1:0] dial_select;
	reg dial_restart;

	wire ctrl_hit = (addr_in == `DTG_OFS_TONE_CONTROL);
	wire dial_hit = (addr_in == `DTG_OFS_DIAL_SELECT);
	wire [`DTG_DIAL_CODE_W-1:0] new_code = wdata_in[`DTG_DIAL_CODE_MSB:0];

	wire tone_output_gate = tone_control[`DTG_BIT_TONE_OUTPUT_GATE];
	wire low_group_disable = tone_control[`DTG_BIT_LOW_GROUP_DISABLE];
	wire high_group_disable = tone_control[`DTG_BIT_HIGH_GROUP_DISABLE];
	wire crystal_select = tone_control[`DTG_BIT_CRYSTAL_SELECT];

	always @(posedge clk_in) begin
		if (!resetn_in) begin
			tone_control <= `DTG_CTRL_RESET;
		end else if (wr_in && ctrl_hit) begin
			// Upper nibble is dropped so it can never steer anything
			tone_control <= wdata_in[`DTG_CTRL_FIELD_W-1:0];
		end
	end

	// Reserved bit 7 and unused bits 6..4 are not stored
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			dial_select <= `DTG_DIAL_RESET;
			dial_restart <= 1'b0;
		end else begin
			dial_restart <= 1'b0;
			if (wr_in && dial_hit) begin
				dial_select <= new_code;
				// Restart both staircases on a new symbol for a clean first cycle
				dial_restart <= (new_code != dial_select);
			end
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	// Unused bits read back as zero; unmapped addresses read zero
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			rdata_out <= `DTG_READ_IDLE;
		end else if (rd_in && ctrl_hit) begin
			rdata_out <= {`DTG_UNUSED_HI, tone_control};
		end else if (rd_in && dial_hit) begin
			rdata_out <= {`DTG_UNUSED_HI, dial_select};
		end else begin
			rdata_out <= `DTG_READ_IDLE;
		end
	end

	// ****************************************
	// Clock divider
	// ****************************************
	// Ratio changes take effect at the next wrap, so a switch never gives a short tick
	reg [`DTG_DIV_W-1:0] div_count;
	reg [`DTG_DIV_W-1:0] div_ratio;
	reg tone_tick;
	wire [`DTG_DIV_W-1:0] next_ratio = crystal_select ? DIV_8M : DIV_4M;
	wire div_wrap = (div_count >= div_ratio - {{(`DTG_DIV_W-1){1'b0}}, 1'b1});

	always @(posedge clk_in) begin
		if (!resetn_in) begin
			div_count <= {`DTG_DIV_W{1'b0}};
			div_ratio <= DIV_4M;
			tone_tick <= 1'b0;
		end else begin
			tone_tick <= div_wrap;
			if (div_wrap) begin
				div_count <= {`DTG_DIV_W{1'b0}};
				div_ratio <= next_ratio;
			end else begin
				div_count <= div_count + {{(`DTG_DIV_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// ****************************************
	// Tone generators
	// ****************************************
	wire [3:0] pair = dial_pair(dial_select);
	wire [`DTG_PERIOD_W-1:0] row_period = low_period(pair[3:2]);
	wire [`DTG_PERIOD_W-1:0] col_period = high_period(pair[1:0]);
	wire row_run = !low_group_disable;
	wire col_run = !high_group_disable;
	wire [`DTG_SAMPLE_W-1:0] row_sample;
	wire [`DTG_SAMPLE_W-1:0] col_sample;

	dtg_stair #(
		.PERIOD_W(`DTG_PERIOD_W)
	) u_low_group (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.run_in(row_run),
		.restart_in(dial_restart),
		.tick_in(tone_tick),
		.period_in(row_period),
		.sample_out(row_sample)
	);

	dtg_stair #(
		.PERIOD_W(`DTG_PERIOD_W)
	) u_high_group (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.run_in(col_run),
		.restart_in(dial_restart),
		.tick_in(tone_tick),
		.period_in(col_period),
		.sample_out(col_sample)
	);

	// ****************************************
	// Adder and output gate
	// ****************************************
	// A stopped generator holds zero, so with both stopped the sum falls back to the midpoint by itself
	wire [`DTG_SUM_W-1:0] mid_wide = {{(`DTG_SUM_W-`DTG_SAMPLE_W){1'b0}}, `DTG_IDLE_LEVEL};
	wire [`DTG_SUM_W-1:0] sum_wide = mid_wide + widen_signed(row_sample) + widen_signed(col_sample);
	wire [`DTG_SAMPLE_W-1:0] next_tone = tone_output_gate ? sum_wide[`DTG_SAMPLE_W-1:0] : `DTG_IDLE_LEVEL;

	always @(posedge clk_in) begin
		if (!resetn_in) begin
			tone_out <= `DTG_IDLE_LEVEL;
			tone_active_out <= 1'b0;
		end else begin
			tone_out <= next_tone;
			tone_active_out <= tone_output_gate;
		end
	end

endmodule

/* dtg_asserts.sv */
// Checker for dtg_top: read-back, output gate, idle level, sum range and restart.
// Assumes one-cycle strobes, back to back allowed, never a write and a read at once.
`timescale 1ns/1ps
module dtg_asserts #(
	parameter [7:0] DIV_4M = 8'h01,
	parameter [7:0] DIV_8M = 8'h02
) (
	input wire clk_in,
	input wire resetn_in,
	input wire [7:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	input wire [7:0] rdata_out,
	input wire [7:0] tone_out,
	input wire tone_active_out
);
	reg [3:0] ctrl_sh;
	reg [3:0] dial_sh;
	wire wr_c = wr_in && addr_in == 8'h20;
	wire wr_d = wr_in && addr_in == 8'h21;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// ********
	// Shadow copies of the stored fields
	// ********
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			ctrl_sh <= 4'h0;
			dial_sh <= 4'h0;
		end else begin
			if (wr_c)
				ctrl_sh <= wdata_in[3:0];
			if (wr_d)
				dial_sh <= wdata_in[3:0];
		end
	end
	property p_rd_idle; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_ctrl_read; rd_in && addr_in == 8'h20 |=> rdata_out == {4'h0, ctrl_sh}; endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read-back wrong");
	property p_dial_read; rd_in && addr_in == 8'h21 |=> rdata_out == {4'h0, dial_sh}; endproperty
	a_dial_read: assert property (p_dial_read) else $error("dial read-back wrong");
	property p_gate_follow; wr_c |-> ##2 tone_active_out == $past(wdata_in[0], 2); endproperty
	a_gate_follow: assert property (p_gate_follow) else $error("gate did not follow write");
	property p_gate_mute; !tone_active_out |-> tone_out == 8'h80; endproperty
	a_gate_mute: assert property (p_gate_mute) else $error("tone leaks with gate closed");
	property p_range; tone_out >= 8'h10 && tone_out <= 8'hF0; endproperty
	a_range: assert property (p_range) else $error("tone sum out of range");
	property p_both_off; (ctrl_sh[2:1] == 2'b11) [*3] |-> tone_out == 8'h80; endproperty
	a_both_off: assert property (p_both_off) else $error("both groups off not idle");
	property p_restart; wr_d && wdata_in[3:0] != dial_sh && ctrl_sh[0] |-> ##[1:4] tone_out == 8'h80; endproperty
	a_restart: assert property (p_restart) else $error("new code did not restart");
	c_restart: cover property (p_restart);
	c_both_off: cover property ((ctrl_sh == 4'h7) [*3]);
	c_gate: cover property ($rose(tone_active_out));
endmodule
bind dtg_top dtg_asserts #(.DIV_4M(DIV_4M), .DIV_8M(DIV_8M)) u_chk (.clk_in(clk_in), .resetn_in(resetn_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.tone_out(tone_out), .tone_active_out(tone_active_out));

/* dtg_line_model.sv */
// Line-side model: loads the tone pin and keeps the highest and lowest level seen.
// Assumes the pin is an unsigned sample on the generator's clock.
`timescale 1ns/1ps
module dtg_line_model (
	input wire clk_in,
	input wire clear_in,
	input wire [7:0] tone_in,
	output reg [7:0] peak_out,
	output reg [7:0] trough_out
);
	// Sampled every cycle, since the pin must never pause
	always @(posedge clk_in) begin
		if (clear_in) begin
			peak_out <= tone_in;
			trough_out <= tone_in;
		end else begin
			if (tone_in > peak_out)
				peak_out <= tone_in;
			if (tone_in < trough_out)
				trough_out <= tone_in;
		end
	end
endmodule

/* dtg_top_test.sv */
// Testbench for dtg_top: registers, gate, sum, symbol map and crystal ratio.
// Assumes the line model on the tone pin and the bound checker.
`timescale 1ns/1ps
`include "dtg_regs.vh"
module dtg_top_test;
	localparam [7:0] DIV_4M = 8'h01;
	localparam [7:0] DIV_8M = 8'h02;
	// Row and column index per code, two bits each, code 0 lowest
	localparam [31:0] ROWS = 32'hE4FA9503;
	localparam [31:0] COLS = 32'hFF892491;
	reg clk_in = 1'b0;
	reg resetn_in = 1'b0;
	reg [7:0] addr_in = 8'h00;
	reg [7:0] wdata_in = 8'h00;
	reg wr_in = 1'b0;
	reg rd_in = 1'b0;
	reg clear = 1'b1;
	wire [7:0] rdata_out;
	wire [7:0] tone_out;
	wire tone_active_out;
	wire [7:0] peak;
	wire [7:0] trough;
	integer n_errors = 0;
	integer comparisons = 0;
	integer i;
	always #25 clk_in = ~clk_in;
	dtg_top #(.DIV_4M(DIV_4M), .DIV_8M(DIV_8M)) i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .tone_out(tone_out),
		.tone_active_out(tone_active_out));
	dtg_line_model i_line (.clk_in(clk_in), .clear_in(clear), .tone_in(tone_out), .peak_out(peak),
		.trough_out(trough));
	// ********
	// Shared tasks
	// ********
	task check(input [15:0] got, input [15:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk_in);
			addr_in <= a;
			wdata_in <= d;
			wr_in <= 1'b1;
			@(posedge clk_in);
			wr_in <= 1'b0;
		end
	endtask
	task rd_chk(input [7:0] a, input [7:0] exp);
		begin
			@(posedge clk_in);
			addr_in <= a;
			rd_in <= 1'b1;
			@(posedge clk_in);
			rd_in <= 1'b0;
			@(posedge clk_in);
			check(rdata_out, exp);
		end
	endtask
	task pulse_clear;
		begin
			clear <= 1'b1;
			@(posedge clk_in);
			clear <= 1'b0;
		end
	endtask
	task next_change(output integer n);
		reg [7:0] v;
		begin
			n = 0;
			v = tone_out;
			do begin
				@(posedge clk_in);
				n = n + 1;
			end while (tone_out === v && n < 3000);
		end
	endtask
	// Third gap is a whole step; the first two may be cut by the control write
	task meas(input [9:0] p, input [7:0] div);
		integer n;
		reg [15:0] e;
		begin
			e = p * div;
			next_change(n);
			next_change(n);
			next_change(n);
			check(n[15:0], e);
		end
	endtask
	function [9:0] per(input lo, input [1:0] k);
		case ({lo, k})
			3'b100: per = `DTG_LOW_TONE_ONE;
			3'b101: per = `DTG_LOW_TONE_TWO;
			3'b110: per = `DTG_LOW_TONE_THREE;
			3'b111: per = `DTG_LOW_TONE_FOUR;
			3'b000: per = `DTG_HIGH_TONE_ONE;
			3'b001: per = `DTG_HIGH_TONE_TWO;
			3'b010: per = `DTG_HIGH_TONE_THREE;
			default: per = `DTG_HIGH_TONE_FOUR;
		endcase
	endfunction
	// ********
	// Scenarios
	// ********
	task t_regs;
		begin
			check(tone_out, 8'h80);
			rd_chk(8'h20, 8'h00);
			wr(8'h20, 8'hF1);
			rd_chk(8'h20, 8'h01);
			check(tone_active_out, 1'b1);
			wr(8'h21, 8'h07);
			rd_chk(8'h21, 8'h07);
			rd_chk(8'h22, 8'h00);
		end
	endtask
	task t_sum;
		integer n;
		begin
			wr(8'h21, 8'h00);
			wr(8'h21, 8'h07);
			repeat (4) @(posedge clk_in);
			pulse_clear;
			next_change(n);
			check(tone_out, 8'h95);
			next_change(n);
			check(tone_out, 8'hAA);
			// Model latches the new level one edge after the pin shows it
			@(posedge clk_in);
			check(peak, 8'hAA);
		end
	endtask
	task t_mute;
		reg [7:0] c;
		begin
			for (i = 0; i < 3; i = i + 1) begin
				c = (i == 0) ? 8'h00 : ((i == 1) ? 8'h06 : 8'h07);
				wr(8'h20, c);
				repeat (3) @(posedge clk_in);
				pulse_clear;
				repeat (400) @(posedge clk_in);
				check(tone_active_out, c[0]);
				check(peak, 8'h80);
				check(trough, 8'h80);
			end
		end
	endtask
	task t_map;
		begin
			for (i = 0; i < 16; i = i + 1) begin
				wr(8'h21, {4'h0, i[3:0]});
				wr(8'h20, 8'h05);
				meas(per(1'b1, ROWS[2*i +: 2]), DIV_4M);
				wr(8'h20, 8'h03);
				meas(per(1'b0, COLS[2*i +: 2]), DIV_4M);
			end
			wr(8'h20, 8'h0D);
			meas(per(1'b1, 2'd3), DIV_8M);
		end
	endtask
	// Mid-run reset must drop the gate and clear both stored fields
	task t_reset;
		begin
			wr(8'h21, 8'h05);
			@(posedge clk_in);
			resetn_in <= 1'b0;
			repeat (2) @(posedge clk_in);
			resetn_in <= 1'b1;
			@(posedge clk_in);
			check(tone_active_out, 1'b0);
			check(tone_out, 8'h80);
			rd_chk(8'h20, 8'h00);
			rd_chk(8'h21, 8'h00);
		end
	endtask
	task tally_and_finish;
		begin
			if (n_errors == 0 && comparisons > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	initial begin
		#4000000;
		n_errors = n_errors + 1;
		tally_and_finish;
	end
	initial begin
		repeat (5) @(posedge clk_in);
		resetn_in <= 1'b1;
		@(posedge clk_in);
		t_regs;
		t_sum;
		t_mute;
		t_map;
		t_reset;
		tally_and_finish;
	end
endmodule
